/* core/bvs_pkg.sv */
package bvs_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned CODE_W = 7;
	localparam int unsigned MV_W   = 16;

	localparam logic [7:0] OFS_TARGET   = 8'h32;
	localparam logic [7:0] OFS_CHOICE_1 = 8'h33;
	localparam logic [7:0] OFS_CHOICE_2 = 8'h34;
	localparam logic [7:0] OFS_CTRL     = 8'h37;

	localparam int unsigned CODE_LSB     = 0;
	localparam int unsigned CODE_MSB     = 6;
	localparam int unsigned WIDE_BIT_POS = 5;

	localparam logic [6:0] RST_TARGET   = 7'h38;
	localparam logic [6:0] RST_CHOICE_1 = 7'h38;
	localparam logic [6:0] RST_CHOICE_2 = 7'h72;
	localparam logic       RST_WIDE     = 1'b1;

	// Voltage scale, all in units of 0.1 mV so that 12.5 mV steps stay integral.
	localparam logic [15:0] V_BASE      = 16'h0fa0;
	localparam logic [15:0] STEP_NARROW = 16'h007d;
	localparam logic [15:0] STEP_FINE   = 16'h00fa;
	localparam logic [15:0] STEP_COARSE = 16'h01f4;
	localparam logic [6:0]  CODE_COARSE = 7'h70;
	localparam logic [15:0] V_COARSE    = 16'h7d00;
	localparam logic [15:0] V_WIDE_MAX  = 16'h8ca0;

	typedef struct packed {
		logic [6:0] target;
		logic [6:0] choice_one;
		logic [6:0] choice_two;
		logic       wide;
		logic [7:0] rdata;
	} bvs_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bvs_bus_t;

endpackage

/* core/bvs_regs.sv */
// Implementation choice: strobed register access.
`timescale 1ns/100ps
// How it works
// - Pin scaling: target read-only, mirrors chosen code.
// - Without pin scaling, target code drives converter.
// - Target at 32h, 7-bit, reset 38h.
// - Choice one at 33h, reset 38h.
// - Choice two at 34h, reset 72h.
// - Wide: 0.4 V, 25 mV, then 50 mV.
// - Narrow: 0.4 V plus 12.5 mV steps.
// - Wide select in control register, resets one.
module bvs_regs
	import bvs_pkg::*;
(
	input  wire logic              SYS_CLK_I,
	input  wire logic              RST_N_I,
	input  wire logic              CLK_EN_I,
	input  wire logic              REG_RESET_I,
	input  wire logic [7:0]        ADDR_I,
	input  wire logic [7:0]        WDATA_I,
	input  wire logic              WR_I,
	input  wire logic              RD_I,
	output logic      [7:0]        RDATA_O,
	input  wire logic              PIN_SCALING_I,
	input  wire logic              PIN_CHOICE_I,
	output logic      [CODE_W-1:0] CONVERTER_CODE_O,
	output logic                   WIDE_RANGE_O,
	output logic      [MV_W-1:0]   VOUT_TENTH_MV_O
);

	bvs_state_t s_q;
	bvs_state_t s_d;
	bvs_bus_t   bus;
	logic [CODE_W-1:0] chosen;
	logic [CODE_W-1:0] active;
	logic [15:0]       vout_d;
	logic [15:0]       vout_q;

	assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

	// The pins pick choice one when low and choice two when high.
	assign chosen = PIN_CHOICE_I ? s_q.choice_two : s_q.choice_one;
	assign active = PIN_SCALING_I ? chosen : s_q.target;

	always_comb begin
		s_d = s_q;
		if (bus.wr) begin
			case (bus.addr)
				OFS_TARGET: begin
					if (!PIN_SCALING_I) begin
						s_d.target = bus.wdata[CODE_MSB:CODE_LSB];
					end
				end
				OFS_CHOICE_1: s_d.choice_one = bus.wdata[CODE_MSB:CODE_LSB];
				OFS_CHOICE_2: s_d.choice_two = bus.wdata[CODE_MSB:CODE_LSB];
				OFS_CTRL:     s_d.wide = bus.wdata[WIDE_BIT_POS];
				default: ;
			endcase
		end
		s_d.rdata = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				OFS_TARGET:   s_d.rdata = {1'b0, active};
				OFS_CHOICE_1: s_d.rdata = {1'b0, s_q.choice_one};
				OFS_CHOICE_2: s_d.rdata = {1'b0, s_q.choice_two};
				OFS_CTRL:     s_d.rdata = {2'b00, s_q.wide, 5'h00};
				default:      s_d.rdata = 8'h00;
			endcase
		end
		// A register reset command reloads target, both choices and the wide bit with their power-on values.
		if (REG_RESET_I) begin
			s_d.target     = RST_TARGET;
			s_d.choice_one = RST_CHOICE_1;
			s_d.choice_two = RST_CHOICE_2;
			s_d.wide       = RST_WIDE;
		end
	end

	// Codes past the top of the wide scale clip at 3.6 V, since the scale stops there.
	always_comb begin
		vout_d = V_BASE;
		if (!s_q.wide) begin
			vout_d = 16'(V_BASE + 16'(active) * STEP_NARROW);
		end else if (active < CODE_COARSE) begin
			vout_d = 16'(V_BASE + 16'(active) * STEP_FINE);
		end else begin
			vout_d = 16'(V_COARSE + 16'(active - CODE_COARSE) * STEP_COARSE);
			if (vout_d > V_WIDE_MAX) begin
				vout_d = V_WIDE_MAX;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			s_q.target     <= RST_TARGET;
			s_q.choice_one <= RST_CHOICE_1;
			s_q.choice_two <= RST_CHOICE_2;
			s_q.wide       <= RST_WIDE;
			s_q.rdata      <= 8'h00;
			vout_q         <= 16'h0000;
		end else if (CLK_EN_I) begin
			s_q    <= s_d;
			vout_q <= vout_d;
		end
	end

	assign RDATA_O          = s_q.rdata;
	assign CONVERTER_CODE_O = active;
	assign WIDE_RANGE_O     = s_q.wide;
	assign VOUT_TENTH_MV_O  = vout_q;

endmodule

/* verif/bvs_host.sv */
`timescale 1ns/100ps
// Host on the register port. Kind 2'b10 writes and 2'b01 reads; strobes last one cycle.
module bvs_host (
	input  wire logic       clk,
	output logic      [7:0] a, d,
	output logic            w, r
);
	initial {a, d, w, r} = '0;
	task acc(input logic [1:0] k, input logic [7:0] ad, dd);
		@(posedge clk) {a, d, w, r} <= {ad, dd, k};
		@(posedge clk) {w, r} <= 2'b00;
	endtask
endmodule

/* verif/bvs_chk.sv */
`timescale 1ns/100ps
module bvs_chk (
	input wire logic        SYS_CLK_I, RST_N_I, CLK_EN_I, REG_RESET_I, WR_I, RD_I,
	input wire logic        PIN_SCALING_I, PIN_CHOICE_I, WIDE_RANGE_O,
	input wire logic [7:0]  ADDR_I, WDATA_I, RDATA_O,
	input wire logic [6:0]  CONVERTER_CODE_O,
	input wire logic [15:0] VOUT_TENTH_MV_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);
	wire       w = CLK_EN_I && !REG_RESET_I && WR_I;
	wire [6:0] c = CONVERTER_CODE_O;
	wire [6:0] v = WDATA_I[6:0];
	sequence s_tw; w && ADDR_I == 8'h32 && !PIN_SCALING_I ##1 !PIN_SCALING_I; endsequence
	sequence s_cw; w && PIN_SCALING_I && ADDR_I == 8'h33 + PIN_CHOICE_I
		##1 PIN_SCALING_I && $stable(PIN_CHOICE_I); endsequence
	AST_RSV: assert property (CLK_EN_I && RD_I |=> !RDATA_O[7]) else $error("rsv");
	AST_PRD: assert property (CLK_EN_I && RD_I && PIN_SCALING_I && ADDR_I == 8'h32
		|=> RDATA_O == {1'b0, $past(c)}) else $error("prd");
	AST_TW: assert property (s_tw |-> c == $past(v)) else $error("tw");
	AST_CW: assert property (s_cw |-> c == $past(v)) else $error("cw");
	AST_RC: assert property ($rose(RST_N_I) && !PIN_SCALING_I |-> c == 7'h38)
		else $error("rc");
	AST_RW: assert property ($rose(RST_N_I) |-> WIDE_RANGE_O) else $error("rw");
	AST_NV: assert property (CLK_EN_I && !WIDE_RANGE_O ##1 CLK_EN_I
		|-> VOUT_TENTH_MV_O == 16'd4000 + 16'd125 * $past(c)) else $error("nv");
	AST_WV: assert property (CLK_EN_I && WIDE_RANGE_O && c < 7'h70 ##1 CLK_EN_I
		|-> VOUT_TENTH_MV_O == 16'd4000 + 16'd250 * $past(c)) else $error("wv");
	AST_CV: assert property (CLK_EN_I && WIDE_RANGE_O && c >= 7'h70 && c <= 7'h78
		##1 CLK_EN_I |-> VOUT_TENTH_MV_O == 16'd32000 + 16'd500 * ($past(c) - 7'h70))
		else $error("cv");
	AST_FRZ: assert property (!CLK_EN_I |=> $stable(VOUT_TENTH_MV_O) && $stable(RDATA_O)
		&& $stable(WIDE_RANGE_O)) else $error("frz");
endmodule
bind bvs_regs bvs_chk i_chk (.*);

/* verif/bvs_tb.sv */
`timescale 1ns/100ps
module testbench;
	logic SYS_CLK_I = 0, RST_N_I = 0, CLK_EN_I = 1, REG_RESET_I = 0;
	logic PIN_SCALING_I = 0, PIN_CHOICE_I = 0, WR_I, RD_I, WIDE_RANGE_O;
	logic [7:0] ADDR_I, WDATA_I, RDATA_O;
	logic [6:0] CONVERTER_CODE_O;
	logic [15:0] VOUT_TENTH_MV_O;
	int mismatches = 0, num_checks = 0;
	always #10 SYS_CLK_I = ~SYS_CLK_I;
	bvs_host i_host (.clk(SYS_CLK_I), .a(ADDR_I), .d(WDATA_I), .w(WR_I), .r(RD_I));
	bvs_regs i_dut (.*);
	task chk(input logic [15:0] s, e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %0t %h!=%h", $time, s, e);
		end
	endtask
	task rc(input logic [7:0] ad, e);
		i_host.acc(2'b01, ad, 8'h00);
		#1 chk(RDATA_O, e);
	endtask
	task t_reg;
		rc(8'h34, 8'h72);
		rc(8'h37, 8'h20);
		i_host.acc(2'b10, 8'h33, 8'hff);
		rc(8'h33, 8'h7f);
		$display("t_reg");
	endtask
	task t_frz;
		@(posedge SYS_CLK_I);
		CLK_EN_I <= 0;
		i_host.acc(2'b10, 8'h33, 8'h22);
		CLK_EN_I <= 1;
		rc(8'h33, 8'h7f);
		$display("t_frz");
	endtask
	task t_pin;
		i_host.acc(2'b10, 8'h32, 8'h10);
		PIN_SCALING_I <= 1;
		i_host.acc(2'b10, 8'h32, 8'h55);
		rc(8'h32, 8'h7f);
		@(posedge SYS_CLK_I);
		PIN_CHOICE_I <= 1;
		rc(8'h32, 8'h72);
		chk(VOUT_TENTH_MV_O, 16'd33000);
		i_host.acc(2'b10, 8'h34, 8'h7f);
		repeat (2) @(posedge SYS_CLK_I);
		#1 chk(CONVERTER_CODE_O, 7'h7f);
		chk(VOUT_TENTH_MV_O, 16'd36000);
		@(posedge SYS_CLK_I);
		PIN_SCALING_I <= 0;
		#1 chk(CONVERTER_CODE_O, 7'h10);
		$display("t_pin");
	endtask
	task t_rng;
		i_host.acc(2'b10, 8'h37, 8'h00);
		repeat (2) @(posedge SYS_CLK_I);
		#1 chk(VOUT_TENTH_MV_O, 16'd6000);
		@(posedge SYS_CLK_I);
		REG_RESET_I <= 1;
		repeat (3) @(posedge SYS_CLK_I);
		#1 chk(VOUT_TENTH_MV_O, 16'd18000);
		$display("t_rng");
	endtask
	task results;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge SYS_CLK_I);
		RST_N_I <= 1;
		t_reg;
		t_frz;
		t_pin;
		t_rng;
		results;
	end
	// The tests need about 60 cycles, so 20 us can only mean a hang.
	initial begin
		#20us;
		mismatches++;
		results;
	end
endmodule
